// [hw/apc_regs.vh]
// register offsets, field positions and reset values of the power and pll configuration bank
`ifndef APC_REGS_VH
`define APC_REGS_VH
`define APC_ADDR_POWER_MODE 7'h37
`define APC_ADDR_TSTAMP_CTRL 7'h3B
`define APC_ADDR_REFOUT_CTRL 7'h3C
`define APC_ADDR_FBDIV_FS 7'h3D
`define APC_ADDR_FBDIV_THIRD 7'h3E
`define APC_ADDR_OSCILLATOR_BIAS_SETTING 7'h3F
`define APC_RST_POWER_MODE 8'h4B
`define APC_RST_TSTAMP_CTRL 8'h00
`define APC_RST_REFOUT_CTRL 8'h01
`define APC_RST_FBDIV_FS 8'h00
`define APC_RST_FBDIV_THIRD 8'h20
`define APC_RST_OSCILLATOR_BIAS_SETTING 8'h4F
`define APC_CODE_LOW_POWER 8'h46
`define APC_CODE_HIGH_PERF 8'h4B
`define APC_BIT_RECV_EN 0
`define APC_BIT_LEVEL_MODE 1
`define APC_BIT_REFOUT_EN 0
`define APC_FLD_FIRST_HI 1
`define APC_FLD_FIRST_LO 0
`define APC_FLD_SECOND_HI 3
`define APC_FLD_SECOND_LO 2
`define APC_FLD_THIRD_HI 5
`define APC_FLD_THIRD_LO 0
`define APC_FLD_BIAS_HI 6
`define APC_FLD_BIAS_LO 0
`endif

// [hw/apc_reg8.v]
// one 8-bit read-write configuration register with reset value
`timescale 1ns/1ps
`default_nettype none
module apc_reg8 #(
    parameter [7:0] RESET_VAL = 8'h00
) (
    input wire sys_clk, // register clock
    input wire rst_b, // async reset, active low
    input wire wr_en, // write strobe for this register
    input wire [7:0] wr_data, // write data
    output reg [7:0] value_q // stored value
);
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            value_q <= RESET_VAL;
        else if (wr_en)
            value_q <= wr_data;
    end
endmodule
`default_nettype wire

// [hw/apc_config_bank.v]
// configuration bank for power mode, timestamp receiver, reference output and pll dividers
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.vh"
// Summary of operation
// - the power mode register takes 0x46 for low power and 0x4B for high performance, resetting to 0x4B.
// - the timestamp receiver is enabled only while bit 0 of its control register is set, reset clear.
// - the reference clock output runs while its enable bit (reset 1) and the pll enable are both high.
// - second feedback divider bits 3:2 divide by 1, 2 or 4 for codes 0, 1, 2; code 3 reserved.
// - first feedback divider bits 1:0 divide by 5, 4 or 3 for codes 0, 1, 2; code 3 reserved.
// - third feedback divider bits 5:0 divide by their value 1 to 63, reset 32.
module apc_config_bank (
    input wire sys_clk, // register clock, 125 MHz
    input wire rst_b, // async reset, active low
    input wire wr_en, // host write strobe, one cycle
    input wire rd_en, // host read strobe, one cycle
    input wire [6:0] addr, // register address
    input wire [7:0] wr_data, // host write data
    output reg [7:0] rd_data_q, // read data, valid cycle after rd_en
    output reg rd_valid_q, // pulse with rd_data_q
    input wire pll_enable, // pll enable level
    input wire clock_pll_reset, // pll held in reset, level
    output reg timestamp_receiver_enable_q, // timestamp input receiver enable
    output reg timestamp_input_level_mode_q, // low voltage pecl mode of timestamp pair
    output reg reference_output_enable_q, // reference clock output driver enable
    output reg low_power_mode_q, // low power operating mode selected
    output reg power_code_reserved_q, // power code written is neither valid code
    output reg [2:0] first_div_ratio_q, // first feedback divide ratio
    output reg [2:0] second_div_ratio_q, // second feedback divide ratio
    output reg [5:0] third_div_ratio_q, // third feedback divide ratio
    output reg div_code_reserved_q, // a reserved divider code is programmed
    output reg [6:0] oscillator_bias_setting_q, // oscillator bias value
    output reg div_change_unsafe_q // a divider field changed while pll was not in reset
);
    localparam NREG = 6;

    wire [7:0] reg_val [0:NREG-1];
    wire [6:0] reg_addr [0:NREG-1];

    assign reg_addr[0] = `APC_ADDR_POWER_MODE;
    assign reg_addr[1] = `APC_ADDR_TSTAMP_CTRL;
    assign reg_addr[2] = `APC_ADDR_REFOUT_CTRL;
    assign reg_addr[3] = `APC_ADDR_FBDIV_FS;
    assign reg_addr[4] = `APC_ADDR_FBDIV_THIRD;
    assign reg_addr[5] = `APC_ADDR_OSCILLATOR_BIAS_SETTING;

    // one storage cell per register; the whole byte is kept so reserved bits read back as written
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1)
        begin : g_reg
            apc_reg8 #(
                .RESET_VAL(gi == 0 ? `APC_RST_POWER_MODE : gi == 1 ? `APC_RST_TSTAMP_CTRL :
                    gi == 2 ? `APC_RST_REFOUT_CTRL : gi == 3 ? `APC_RST_FBDIV_FS :
                    gi == 4 ? `APC_RST_FBDIV_THIRD : `APC_RST_OSCILLATOR_BIAS_SETTING)
            ) u_reg (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .wr_en(wr_en && addr == reg_addr[gi]), // full byte stored, reserved bits too
                .wr_data(wr_data),
                .value_q(reg_val[gi])
            );
        end
    endgenerate

    // unmapped reads return zero rather than echoing a neighbour
    reg [7:0] rd_mux;
    always @*
    begin
        if (addr == `APC_ADDR_POWER_MODE)
            rd_mux = reg_val[0];
        else if (addr == `APC_ADDR_TSTAMP_CTRL)
            rd_mux = reg_val[1];
        else if (addr == `APC_ADDR_REFOUT_CTRL)
            rd_mux = reg_val[2];
        else if (addr == `APC_ADDR_FBDIV_FS)
            rd_mux = reg_val[3];
        else if (addr == `APC_ADDR_FBDIV_THIRD)
            rd_mux = reg_val[4];
        else if (addr == `APC_ADDR_OSCILLATOR_BIAS_SETTING)
            rd_mux = reg_val[5];
        else
            rd_mux = 8'h00; // unmapped addresses read zero
    end
    wire [1:0] first_code = reg_val[3][`APC_FLD_FIRST_HI:`APC_FLD_FIRST_LO];
    wire [1:0] second_code = reg_val[3][`APC_FLD_SECOND_HI:`APC_FLD_SECOND_LO];
    wire [5:0] third_code = reg_val[4][`APC_FLD_THIRD_HI:`APC_FLD_THIRD_LO];
    wire power_low_sel = (reg_val[0] == `APC_CODE_LOW_POWER);
    wire power_high_sel = (reg_val[0] == `APC_CODE_HIGH_PERF);
    wire div_reserved = (first_code == 2'h3) || (second_code == 2'h3) || (third_code == 6'h00);
    reg [2:0] first_ratio;
    reg [2:0] second_ratio;

    always @*
    begin
        case (first_code)
            2'h0: first_ratio = 3'h5;
            2'h1: first_ratio = 3'h4;
            2'h2: first_ratio = 3'h3;
            default: first_ratio = 3'h5; // reserved code keeps the default ratio
        endcase
        case (second_code)
            2'h0: second_ratio = 3'h1;
            2'h1: second_ratio = 3'h2;
            2'h2: second_ratio = 3'h4;
            default: second_ratio = 3'h1;
        endcase
    end

    // read data held until the next read so a slow host can fetch it late
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end
        else
        begin
            rd_valid_q <= rd_en;
            if (rd_en)
                rd_data_q <= rd_mux;
        end
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timestamp_receiver_enable_q <= 1'b0;
            timestamp_input_level_mode_q <= 1'b0;
        end
        else
        begin
            timestamp_receiver_enable_q <= reg_val[1][`APC_BIT_RECV_EN];
            timestamp_input_level_mode_q <= reg_val[1][`APC_BIT_LEVEL_MODE];
        end
    end

    // reserved power codes are stored and flagged, never coerced to a valid mode
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            low_power_mode_q <= 1'b0;
            power_code_reserved_q <= 1'b0;
        end
        else
        begin
            low_power_mode_q <= power_low_sel;
            power_code_reserved_q <= !power_low_sel && !power_high_sel;
        end
    end

    // follows pll_enable one edge late, like every other derived output
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            reference_output_enable_q <= 1'b0;
        else
            reference_output_enable_q <= reg_val[2][`APC_BIT_REFOUT_EN] && pll_enable;
    end

    // reserved first and second codes fall back to the default ratios, a zero third code passes through as 0; all raise the flag
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            first_div_ratio_q <= 3'h5;
            second_div_ratio_q <= 3'h1;
            third_div_ratio_q <= 6'h20;
            div_code_reserved_q <= 1'b0;
        end
        else
        begin
            first_div_ratio_q <= first_ratio;
            second_div_ratio_q <= second_ratio;
            third_div_ratio_q <= third_code;
            div_code_reserved_q <= div_reserved;
        end
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            oscillator_bias_setting_q <= 7'h4F;
        else
            oscillator_bias_setting_q <= reg_val[5][`APC_FLD_BIAS_HI:`APC_FLD_BIAS_LO];
    end

    // previous divider fields, used to flag changes made outside pll reset
    reg [7:0] div_prev_q;
    reg [5:0] third_prev_q;
    wire div_changed = (div_prev_q[3:0] != reg_val[3][3:0]) || (third_prev_q != third_code);
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_prev_q <= `APC_RST_FBDIV_FS;
            third_prev_q <= 6'h20;
            div_change_unsafe_q <= 1'b0;
        end
        else
        begin
            div_prev_q <= reg_val[3];
            third_prev_q <= third_code;
            // sticky: only reset clears it, so a careless sequence stays visible
            if (div_changed && !clock_pll_reset)
                div_change_unsafe_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [testbench/apc_config_bank_asserts.sv]
// port assertions for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module apc_config_checker (
    input wire logic sys_clk, rst_b, wr_en, rd_en, rd_valid_q, pll_enable, // bus side
    input wire logic timestamp_receiver_enable_q, reference_output_enable_q, low_power_mode_q, // controls
    input wire logic [6:0] addr, input wire logic [7:0] wr_data, // bus side
    input wire logic [2:0] first_div_ratio_q, second_div_ratio_q, input wire logic [5:0] third_div_ratio_q // ratios
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_rd; rd_en |=> rd_valid_q; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_ts; wr_en && addr == 7'h3B |=> ##1 timestamp_receiver_enable_q == $past(wr_data[0], 2); endproperty
    a_ts: assert property (p_ts) else $error("timestamp enable wrong");
    property p_po; !pll_enable |=> !reference_output_enable_q; endproperty
    a_po: assert property (p_po) else $error("reference out without pll");
    property p_ro; wr_en && addr == 7'h3C && wr_data[0] ##1 pll_enable |=> reference_output_enable_q; endproperty
    a_ro: assert property (p_ro) else $error("reference out missing");
    property p_lp; wr_en && addr == 7'h37 |=> ##1 low_power_mode_q == ($past(wr_data, 2) == 8'h46); endproperty
    a_lp: assert property (p_lp) else $error("power mode wrong");
    property p_d1; wr_en && addr == 7'h3D |=> ##1 first_div_ratio_q == 3'd5 - $past(wr_data[1:0], 2) % 2'd3; endproperty
    a_d1: assert property (p_d1) else $error("first ratio wrong");
    property p_d2; wr_en && addr == 7'h3D |=> ##1 second_div_ratio_q == 3'd1 << ($past(wr_data[3:2], 2) % 2'd3);
    endproperty
    a_d2: assert property (p_d2) else $error("second ratio wrong");
    property p_d3; wr_en && addr == 7'h3E |=> ##1 third_div_ratio_q == $past(wr_data[5:0], 2); endproperty
    a_d3: assert property (p_d3) else $error("third ratio wrong");
endmodule
bind apc_config_bank apc_config_checker apc_config_checker_inst (.*);
`default_nettype wire

// [testbench/apc_host_model.sv]
// host model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module apc_host_model (
    input wire logic sys_clk, output logic wr_en = 1'b0, output logic rd_en = 1'b0, // clock, strobes
    output logic [6:0] addr = 7'h00, output logic [7:0] wr_data = 8'h00 // address, data
);
    task automatic go(input logic r, input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1 wr_en = !r;
        rd_en = r;
        addr = a;
        wr_data = d;
        @(posedge sys_clk) #1 wr_en = 1'b0;
        rd_en = 1'b0;
        wr_data = ~d; // inverse so stale data never looks valid
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// random bench of the configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0, rst_b = 1'b0, pll_enable = 1'b1, clock_pll_reset = 1'b1;
    logic [7:0] p;
    wire rv, tre, tlm, roe, lpm, pcr, dcr, dcu, wr_en, rd_en;
    wire [6:0] addr, bias;
    wire [7:0] wr_data, rd_data_q;
    wire [2:0] r1, r2;
    wire [5:0] r3;
    int bad_count = 0, tests_run = 0;
    always #4 sys_clk = ~sys_clk;
    apc_host_model apc_host_model_inst (.sys_clk, .wr_en, .rd_en, .addr, .wr_data);
    apc_config_bank apc_config_bank_inst (.sys_clk, .rst_b, .wr_en, .rd_en, .addr, .wr_data, .rd_data_q,
        .rd_valid_q(rv), .pll_enable, .clock_pll_reset, .timestamp_receiver_enable_q(tre),
        .timestamp_input_level_mode_q(tlm), .reference_output_enable_q(roe), .low_power_mode_q(lpm),
        .power_code_reserved_q(pcr), .first_div_ratio_q(r1), .second_div_ratio_q(r2), .third_div_ratio_q(r3),
        .div_code_reserved_q(dcr), .oscillator_bias_setting_q(bias), .div_change_unsafe_q(dcu));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        bad_count += int'(g !== e);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        void'($urandom(79));
        repeat (12) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        @(posedge sys_clk) #1 chk({bias, r1, r2, r3, tre, roe, lpm}, {7'h4F, 3'd5, 3'd1, 6'd32, 3'b010});
        // pll reset stays high so divider changes are legal; k*21 hits 0 and 63
        for (int k = 0; k < 16; k++)
        begin
            pll_enable = k[2];
            p = k[0] ? 8'h46 : k[1] ? 8'($urandom) | 8'h80 : 8'h4B;
            // bench rate is at or below 1 GSPS; calibration, serial link and the other power registers live outside
            apc_host_model_inst.go(1'b0, 7'h37, p);
            apc_host_model_inst.go(1'b0, 7'h3B, {6'h0, k[1:0]});
            apc_host_model_inst.go(1'b0, 7'h3C, {7'h0, k[1]});
            apc_host_model_inst.go(1'b0, 7'h3E, 8'(k * 21) & 8'h3F);
            apc_host_model_inst.go(1'b0, 7'h3D, 8'(k));
            @(posedge sys_clk) #1 chk({tre, tlm, roe, lpm, pcr, dcr, dcu, r1, r2, r3}, {k[0], k[1], k[2] & k[1],
                p == 8'h46, p[7], k[1:0] == 3 || k[3:2] == 3 || k == 0, 1'b0, 3'd5 - k[1:0] % 2'd3,
                3'd1 << (k[3:2] % 2'd3), 6'(k * 21)});
            apc_host_model_inst.go(1'b1, k == 15 ? 7'h40 : k[0] ? 7'h3D : 7'h37, 8'h00);
            chk({rv, rd_data_q}, {1'b1, k == 15 ? 8'h00 : k[0] ? 8'(k) : p});
        end
        // bias write, then a divider change with the pll out of reset on purpose to trip the sticky flag
        apc_host_model_inst.go(1'b0, 7'h3F, 8'h4A);
        clock_pll_reset = 1'b0;
        apc_host_model_inst.go(1'b0, 7'h3D, 8'h01);
        @(posedge sys_clk) #1 chk({bias, dcu}, {7'h4A, 1'b1});
        // second reset in mid-run: only reset clears the flag
        rst_b = 1'b0;
        clock_pll_reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        @(posedge sys_clk) #1 chk({dcu, lpm, tre, roe, bias, rv}, {3'b000, 1'b1, 7'h4F, 1'b0});
        report_and_stop;
    end
endmodule
`default_nettype wire
